//--- core/sleep_gate_pkg.sv
// package: register map, fields and constants of the sleep clock gating block
`default_nettype none
package sleep_gate_pkg;
  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_PERIPH = 32;
  localparam int unsigned NUM_INT_SRC = 4;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned VSEL_W = 4;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_GATING = 12'h000;
  localparam logic [11:0] OFS_RUN_EN = 12'h004;
  localparam logic [11:0] OFS_SLEEP_EN = 12'h008;
  localparam logic [11:0] OFS_DSLEEP_EN = 12'h00c;
  localparam logic [11:0] OFS_INT_RAW = 12'h010;
  localparam logic [11:0] OFS_INT_MASK = 12'h014;
  localparam logic [11:0] OFS_INT_VIEW = 12'h018;
  localparam logic [11:0] OFS_REG_VOLT = 12'h01c;
  localparam logic [11:0] OFS_CLK_STAT = 12'h020;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned BIT_GATING_ON = 0;
  localparam int unsigned BIT_MASKED_VIEW = 1;
  localparam int unsigned BIT_MAIN_OSC_PUP = 0;
  localparam int unsigned BIT_USB_PLL_LOCK = 1;
  localparam int unsigned BIT_SYS_PLL_LOCK = 2;
  localparam int unsigned BIT_BROWNOUT = 3;

  // ----------------------------------------------------------------------
  // regulator settings: code 0 = 2.25 V, step 50 mV, code 10 = 2.75 V
  // ----------------------------------------------------------------------
  localparam logic [3:0] VSEL_MAX = 4'ha;
  localparam logic [3:0] VSEL_DEFAULT = 4'h5;

  // ----------------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP_SLEEP = 2'b10
  } power_mode_t;
endpackage : sleep_gate_pkg
`default_nettype wire

//--- core/sync2.sv
// two-flop synchroniser for a WIDTH-bit group of levels
`default_nettype none
module sync2
  import sleep_gate_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1_reg <= '0;
      sync_o <= '0;
    end else if (ce_i) begin
      stage1_reg <= async_i;
      sync_o <= stage1_reg;
    end
  end
endmodule : sync2
`default_nettype wire

//--- core/clk_gate_cell.sv
// latch-based glitch-free clock gate for one peripheral
`default_nettype none
module clk_gate_cell (
  input wire logic clk_sys_i,
  input wire logic enable_i,
  output logic gclk_o
);
  logic en_latch;

  // transparent while the clock is low, so enable only moves then
  always_latch begin
    if (!clk_sys_i) begin
      en_latch <= enable_i;
    end
  end

  assign gclk_o = clk_sys_i & en_latch;
endmodule : clk_gate_cell
`default_nettype wire

//--- core/sleep_clock_gating_status.sv
// sleep clock gating, system interrupt status and regulator setting
//
// Functional notes
// R1 - status reads raw or masked, picked by masked view select
// R2 - one status bit each: osc power-up, usb pll, sys pll, brown-out
// R3 - only enabled sources reach the irq; raw flags still record events
// R4 - gating off (reset): sleep clocks equal run clocks
// R5 - gating on: sleep uses sleep enables, deep-sleep uses deep enables
// R6 - gating on: deep-sleep clock stops where deep enable is clear
// R7 - gating on: deep-sleep clock runs where deep enable is set
// R8 - leaving deep-sleep restores run clocks, no reset of state
// R9 - sleep and deep enables kept while gating off, no effect
// R10 - regulator field, eleven settings, resets to 2.5 V code
// R11 - regulator read returns the held setting code
// R12 - per-peripheral sleep and deep bits plus global gating bit
// R13 - clock enables combinational from mode and bits, glitch-free
//
// Decided for this implementation: the placing of the registers and the APB register port.
`default_nettype none
module sleep_clock_gating_status
  import sleep_gate_pkg::*;
#(
  parameter int unsigned NPER = NUM_PERIPH
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleeping_i,
  input wire logic deep_sleeping_i,
  input wire logic [NUM_INT_SRC-1:0] int_event_i,
  output logic irq_o,
  output logic [NPER-1:0] periph_clk_en_o,
  output logic [NPER-1:0] periph_clk_o,
  output logic [VSEL_W-1:0] regulator_voltage_setting_o
);
  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [NUM_INT_SRC+1:0] sync_out;
  logic [NUM_INT_SRC-1:0] event_sync;
  logic [NUM_INT_SRC-1:0] event_prev_reg;
  logic [NUM_INT_SRC-1:0] event_rise;
  logic sleep_sync;
  logic deep_sync;

  sync2 #(
    .WIDTH(NUM_INT_SRC + 2)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .async_i({deep_sleeping_i, sleeping_i, int_event_i}),
    .sync_o(sync_out)
  );

  assign event_sync = sync_out[NUM_INT_SRC-1:0];
  assign sleep_sync = sync_out[NUM_INT_SRC];
  assign deep_sync = sync_out[NUM_INT_SRC+1];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_prev_reg <= '0;
    end else if (ce_i) begin
      event_prev_reg <= event_sync;
    end
  end

  assign event_rise = event_sync & ~event_prev_reg;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // zero wait states: every access completes in its first access cycle
  assign pready_o = 1'b1;
  assign wr_en = ce_i & psel_i & penable_i & pwrite_i & (&pstrb_i);
  assign rd_en = ce_i & psel_i & penable_i & ~pwrite_i;

  always_comb begin
    if (paddr_i == OFS_GATING) begin
      addr_ok = 1'b1;
    end else if (paddr_i == OFS_RUN_EN || paddr_i == OFS_SLEEP_EN) begin
      addr_ok = 1'b1;
    end else if (paddr_i == OFS_DSLEEP_EN || paddr_i == OFS_INT_RAW) begin
      addr_ok = 1'b1;
    end else if (paddr_i == OFS_INT_MASK || paddr_i == OFS_INT_VIEW) begin
      addr_ok = 1'b1;
    end else if (paddr_i == OFS_REG_VOLT || paddr_i == OFS_CLK_STAT) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr_o = psel_i & penable_i & ~addr_ok;

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  logic sleep_gating_on_reg;
  logic masked_view_select_reg;
  logic [NPER-1:0] run_en_reg;
  logic [NPER-1:0] sleep_en_reg;
  logic [NPER-1:0] dsleep_en_reg;
  logic [VSEL_W-1:0] vsel_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_gating_on_reg <= 1'b0; // R4
      masked_view_select_reg <= 1'b0;
    end else if (wr_en && paddr_i == OFS_GATING) begin
      sleep_gating_on_reg <= pwdata_i[BIT_GATING_ON]; // R12
      masked_view_select_reg <= pwdata_i[BIT_MASKED_VIEW]; // R1
    end
  end

  // stored bits persist whatever the gating control says
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_en_reg <= '0;
      sleep_en_reg <= '0;
      dsleep_en_reg <= '0;
    end else if (wr_en) begin
      if (paddr_i == OFS_RUN_EN) begin
        run_en_reg <= pwdata_i[NPER-1:0];
      end else if (paddr_i == OFS_SLEEP_EN) begin
        sleep_en_reg <= pwdata_i[NPER-1:0]; // R12 R9
      end else if (paddr_i == OFS_DSLEEP_EN) begin
        dsleep_en_reg <= pwdata_i[NPER-1:0]; // R12 R9
      end
    end
  end

  // out-of-range codes are ignored so the field always holds a legal one
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vsel_reg <= VSEL_DEFAULT; // R10
    end else if (wr_en && paddr_i == OFS_REG_VOLT) begin
      if (pwdata_i[VSEL_W-1:0] <= VSEL_MAX) begin
        vsel_reg <= pwdata_i[VSEL_W-1:0]; // R10
      end
    end
  end

  assign regulator_voltage_setting_o = vsel_reg;

  // ----------------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------------
  logic [NUM_INT_SRC-1:0] int_raw_reg;
  logic [NUM_INT_SRC-1:0] int_mask_reg;
  logic [NUM_INT_SRC-1:0] int_clr;
  logic [NUM_INT_SRC-1:0] int_masked;

  assign int_clr = (wr_en && paddr_i == OFS_INT_RAW) ?
                   pwdata_i[NUM_INT_SRC-1:0] : '0;

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_raw_reg <= '0;
    end else if (ce_i) begin
      int_raw_reg <= (int_raw_reg & ~int_clr) | event_rise; // R2 R3
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_mask_reg <= '0;
    end else if (wr_en && paddr_i == OFS_INT_MASK) begin
      int_mask_reg <= pwdata_i[NUM_INT_SRC-1:0];
    end
  end

  assign int_masked = int_raw_reg & int_mask_reg; // R3
  assign irq_o = |int_masked; // R3

  // ----------------------------------------------------------------------
  // power mode and clock enables
  // ----------------------------------------------------------------------
  power_mode_t mode;
  logic [NPER-1:0] clk_en;

  always_comb begin
    if (deep_sync) begin
      mode = MODE_DEEP_SLEEP;
    end else if (sleep_sync) begin
      mode = MODE_SLEEP;
    end else begin
      mode = MODE_RUN;
    end
  end

  // run clocks return as soon as the mode drops back; nothing is reset
  always_comb begin
    case (mode)
      MODE_SLEEP: begin
        clk_en = sleep_gating_on_reg ? sleep_en_reg : run_en_reg; // R4 R5
      end
      MODE_DEEP_SLEEP: begin
        clk_en = sleep_gating_on_reg ? dsleep_en_reg : run_en_reg; // R6 R7
      end
      default: begin
        clk_en = run_en_reg; // R8
      end
    endcase
  end

  assign periph_clk_en_o = clk_en; // R13

  genvar gi;
  generate
    for (gi = 0; gi < NPER; gi++) begin : g_gate
      clk_gate_cell u_gate (
        .clk_sys_i(clk_sys_i),
        .enable_i(clk_en[gi]),
        .gclk_o(periph_clk_o[gi])
      ); // R13
    end
  endgenerate

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] rdata_next;

  always_comb begin
    rdata_next = '0;
    if (paddr_i == OFS_GATING) begin
      rdata_next[BIT_GATING_ON] = sleep_gating_on_reg;
      rdata_next[BIT_MASKED_VIEW] = masked_view_select_reg;
    end else if (paddr_i == OFS_RUN_EN) begin
      rdata_next[NPER-1:0] = run_en_reg;
    end else if (paddr_i == OFS_SLEEP_EN) begin
      rdata_next[NPER-1:0] = sleep_en_reg;
    end else if (paddr_i == OFS_DSLEEP_EN) begin
      rdata_next[NPER-1:0] = dsleep_en_reg;
    end else if (paddr_i == OFS_INT_RAW) begin
      rdata_next[NUM_INT_SRC-1:0] = int_raw_reg;
    end else if (paddr_i == OFS_INT_MASK) begin
      rdata_next[NUM_INT_SRC-1:0] = int_mask_reg;
    end else if (paddr_i == OFS_INT_VIEW) begin
      rdata_next[NUM_INT_SRC-1:0] = masked_view_select_reg ?
                                    int_masked : int_raw_reg; // R1
    end else if (paddr_i == OFS_REG_VOLT) begin
      rdata_next[VSEL_W-1:0] = vsel_reg; // R11
    end else if (paddr_i == OFS_CLK_STAT) begin
      rdata_next[NPER-1:0] = clk_en;
    end
  end

  // prdata is registered on the setup cycle, valid in the access cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0;
    end else if (ce_i && psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rdata_next;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_masked_irq_gate: assert property ( // R3
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    irq_o == |(int_raw_reg & int_mask_reg))
  else $error("irq disagrees with masked status");

  chk_gating_off_run: assert property ( // R4
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !sleep_gating_on_reg |-> periph_clk_en_o == run_en_reg)
  else $error("gating off but enables differ from run");

  chk_sleep_enables: assert property ( // R5
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    sleep_gating_on_reg && sleep_sync && !deep_sync
    |-> periph_clk_en_o == sleep_en_reg)
  else $error("sleep enables not applied");

  chk_deep_stop: assert property ( // R6
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    sleep_gating_on_reg && deep_sync
    |-> (periph_clk_en_o & ~dsleep_en_reg) == '0)
  else $error("clock runs with deep enable clear");

  chk_deep_keep: assert property ( // R7
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    sleep_gating_on_reg && deep_sync
    |-> (dsleep_en_reg & ~periph_clk_en_o) == '0)
  else $error("clock stopped with deep enable set");

  chk_wake_restore: assert property ( // R8
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(deep_sync) && !sleep_sync |-> periph_clk_en_o == run_en_reg)
  else $error("run clocks not restored on wake");

  chk_event_sticks: assert property ( // R2
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ce_i && event_rise[BIT_BROWNOUT] |=> int_raw_reg[BIT_BROWNOUT])
  else $error("brown-out event lost");

  chk_volt_legal: assert property ( // R10
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    vsel_reg <= VSEL_MAX)
  else $error("regulator code out of range");

  chk_volt_read: assert property ( // R11
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    psel_i && !penable_i && !pwrite_i && ce_i && paddr_i == OFS_REG_VOLT
    && !(wr_en) |=> prdata_o == {{(DATA_W-VSEL_W){1'b0}}, vsel_reg})
  else $error("regulator read mismatch");
endmodule : sleep_clock_gating_status
`default_nettype wire

//--- tb/tb_top.sv
// self-checking testbench for the sleep clock gating and status block
`default_nettype none
module tb_top;
  import sleep_gate_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel, penable, pwrite, sleeping, deep_sleeping, ce;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata_o;
  logic [3:0] pstrb;
  logic [NUM_INT_SRC-1:0] int_event;
  logic pready_o, pslverr_o, irq_o;
  logic [NUM_PERIPH-1:0] periph_clk_en_o, periph_clk_o;
  logic [VSEL_W-1:0] regulator_voltage_setting_o;
  int miscompares = 0;
  int n_tests = 0;
  localparam logic [31:0] RUN_V = 32'hffff00ff;
  // sleep and deep patterns are subsets of the run pattern on purpose
  localparam logic [31:0] SLP_V = 32'h0f0f000f;
  localparam logic [31:0] DSL_V = 32'h00ff0003;

  always #50 clk_sys_i = ~clk_sys_i;

  sleep_clock_gating_status #(
    .NPER(NUM_PERIPH)
  ) sleep_clock_gating_status_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sleeping_i(sleeping), .deep_sleeping_i(deep_sleeping),
    .int_event_i(int_event), .irq_o(irq_o),
    .periph_clk_en_o(periph_clk_en_o), .periph_clk_o(periph_clk_o),
    .regulator_voltage_setting_o(regulator_voltage_setting_o)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1, "pready never came");
    r = prdata_o;
    e = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hf, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, 4'hf, r, e);
    chk(r, exp, "read data");
    chk(e, 1'b0, "unexpected slave error");
  endtask : rd

  task automatic mode(input logic s, input logic d, input logic [31:0] exp);
    sleeping <= s;
    deep_sleeping <= d;
    repeat (4) @(posedge clk_sys_i);
    chk(periph_clk_en_o, exp, "clock enables");
    rd(OFS_CLK_STAT, exp);
    @(posedge clk_sys_i);
    #25;
    // in the high phase each gated clock shows its enable
    chk(periph_clk_o, exp, "gated clocks");
  endtask : mode

  task automatic event_pulse(input logic [3:0] v);
    int_event <= v;
    repeat (5) @(posedge clk_sys_i);
    int_event <= 4'h0;
    repeat (5) @(posedge clk_sys_i);
  endtask : event_pulse

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset;
    chk(regulator_voltage_setting_o, VSEL_DEFAULT, "regulator reset");
    chk(periph_clk_en_o, 32'h0, "enables reset");
    chk(irq_o, 1'b0, "irq reset");
    rd(OFS_REG_VOLT, 32'h5);
    rd(OFS_GATING, 32'h0);
    rd(OFS_INT_RAW, 32'h0);
  endtask : t_reset

  task automatic t_regulator;
    logic [31:0] r;
    logic e;
    wr(OFS_REG_VOLT, 32'h0);
    rd(OFS_REG_VOLT, 32'h0);
    wr(OFS_REG_VOLT, 32'ha);
    rd(OFS_REG_VOLT, 32'ha);
    chk(regulator_voltage_setting_o, VSEL_MAX, "regulator port");
    // an undefined code must leave the held setting alone
    wr(OFS_REG_VOLT, 32'hb);
    rd(OFS_REG_VOLT, 32'ha);
    apb(1'b1, OFS_REG_VOLT, 32'h3, 4'h7, r, e);
    rd(OFS_REG_VOLT, 32'ha);
    apb(1'b1, 12'h024, 32'hffffffff, 4'hf, r, e);
    // with the clock enable low neither a write nor an event may land
    ce <= 1'b0;
    wr(OFS_REG_VOLT, 32'h2);
    event_pulse(4'h1);
    ce <= 1'b1;
    rd(OFS_REG_VOLT, 32'ha);
    rd(OFS_INT_RAW, 32'h0);
    apb(1'b1, 12'h024, 32'hffffffff, 4'hf, r, e);
    chk(e, 1'b1, "unmapped write error");
    apb(1'b0, 12'h024, 32'h0, 4'hf, r, e);
    chk(e, 1'b1, "unmapped read error");
    chk(r, 32'h0, "unmapped read data");
  endtask : t_regulator

  task automatic t_interrupts;
    wr(OFS_INT_MASK, 32'h0);
    event_pulse(4'h9);
    rd(OFS_INT_RAW, 32'h9);
    chk(irq_o, 1'b0, "masked source reached irq");
    rd(OFS_INT_VIEW, 32'h9);
    wr(OFS_GATING, 32'h2);
    rd(OFS_INT_VIEW, 32'h0);
    wr(OFS_INT_MASK, 32'h8);
    rd(OFS_INT_VIEW, 32'h8);
    chk(irq_o, 1'b1, "enabled source missing");
    wr(OFS_INT_RAW, 32'h8);
    rd(OFS_INT_RAW, 32'h1);
    chk(irq_o, 1'b0, "irq after clear");
    event_pulse(4'h6);
    rd(OFS_INT_RAW, 32'h7);
    wr(OFS_INT_MASK, 32'h4);
    rd(OFS_INT_MASK, 32'h4);
    chk(irq_o, 1'b1, "sys pll source irq");
    wr(OFS_INT_RAW, 32'hf);
    rd(OFS_INT_RAW, 32'h0);
    wr(OFS_GATING, 32'h0);
  endtask : t_interrupts

  task automatic t_gating;
    wr(OFS_RUN_EN, RUN_V);
    wr(OFS_SLEEP_EN, SLP_V);
    wr(OFS_DSLEEP_EN, DSL_V);
    rd(OFS_SLEEP_EN, SLP_V);
    rd(OFS_DSLEEP_EN, DSL_V);
    mode(1'b0, 1'b0, RUN_V);
    mode(1'b1, 1'b0, RUN_V);
    mode(1'b0, 1'b1, RUN_V);
    mode(1'b0, 1'b0, RUN_V);
    wr(OFS_GATING, 32'h1);
    rd(OFS_GATING, 32'h1);
    mode(1'b0, 1'b0, RUN_V);
    mode(1'b1, 1'b0, SLP_V);
    mode(1'b0, 1'b1, DSL_V);
    mode(1'b1, 1'b1, DSL_V);
    mode(1'b0, 1'b0, RUN_V);
    rd(OFS_RUN_EN, RUN_V);
    wr(OFS_GATING, 32'h0);
    mode(1'b0, 1'b1, RUN_V);
    mode(1'b0, 1'b0, RUN_V);
  endtask : t_gating

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    sleeping = 1'b0;
    deep_sleeping = 1'b0;
    ce = 1'b1;
    int_event = 4'h0;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_regulator();
    t_interrupts();
    t_gating();
    report_and_stop();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #2000000;
    miscompares++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
